// file: design/rpcg_regs.svh
// register offsets, field positions and reset values of the peripheral clock gate block
`ifndef RPCG_REGS_SVH
`define RPCG_REGS_SVH
`define RPCG_OFF_RUN_GATES 12'h104
`define RPCG_OFF_SLEEP_GATES 12'h114
`define RPCG_OFF_DSLEEP_GATES 12'h124
`define RPCG_OFF_CLK_CONFIG 12'h060
`define RPCG_OFF_IRQ_STATUS 12'h200
`define RPCG_OFF_IRQ_MASK 12'h204
`define RPCG_GATES_RESET 32'h00000000
`define RPCG_GATES_WMASK 32'h010f5037
`define RPCG_CFG_RESET 32'h00000000
`define RPCG_CFG_AUTO_GATING_BIT 27
`define RPCG_IRQ_FAULT_BIT 0
`define RPCG_IRQ_WMASK 32'h00000001
`define RPCG_IRQ_RESET 32'h00000000
// gating bit position of each controlled peripheral
`define RPCG_BIT_ASYNC_SERIAL_0 5'd0
`define RPCG_BIT_ASYNC_SERIAL_1 5'd1
`define RPCG_BIT_ASYNC_SERIAL_2 5'd2
`define RPCG_BIT_SYNC_SERIAL_0 5'd4
`define RPCG_BIT_SYNC_SERIAL_1 5'd5
`define RPCG_BIT_TWO_WIRE_0 5'd12
`define RPCG_BIT_TWO_WIRE_1 5'd14
`define RPCG_BIT_GP_COUNTER_0 5'd16
`define RPCG_BIT_GP_COUNTER_1 5'd17
`define RPCG_BIT_GP_COUNTER_2 5'd18
`define RPCG_BIT_GP_COUNTER_3 5'd19
`define RPCG_BIT_COMPARATOR_0 5'd24
`define RPCG_NUM_GATES 12
`endif

// file: design/rpcg_pkg.sv
// types shared by the peripheral clock gate block
package rpcg_pkg;
  typedef enum logic [2:0] {
    RPCG_RUN = 3'b001,
    RPCG_SLEEP = 3'b010,
    RPCG_DEEP_SLEEP = 3'b100
  } rpcg_power_mode_e;
  typedef logic [31:0] rpcg_word_t;
endpackage

// file: design/rpcg_gate_reg.sv
// one 32-bit gating register with read-write bits selected by a mask
`timescale 1ns/10ps
module rpcg_gate_reg #(
  parameter logic [31:0] WMASK = 32'h00000000,
  parameter logic [31:0] RESET = 32'h00000000
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write port
  input wire logic wr_en,
  input wire logic [31:0] wdata,
  // stored value
  output logic [31:0] value
);
  wire [31:0] next_value = (wdata & WMASK) | (value & ~WMASK);

  // reserved positions never take a write, so they always read as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value <= RESET;
    end else if (wr_en) begin
      value <= next_value;
    end
  end
endmodule

// file: design/rpcg_clock_gate.sv
// glitch-free latch-based clock gate for one peripheral
`timescale 1ns/10ps
module rpcg_clock_gate (
  // clock in
  input wire logic clk_in,
  // enable, synchronous to clk_in
  input wire logic enable,
  // gated clock out
  output logic clk_out
);
  logic enable_latched;

  // latch while the clock is low so a change never chops a high phase
  always_latch begin
    if (!clk_in) begin
      enable_latched = enable;
    end
  end

  assign clk_out = clk_in & enable_latched;
endmodule

// file: design/rpcg_top.sv
// run-mode peripheral clock gate with apb registers and bus-fault decision
// Overview of operation
// [RQ1] each peripheral clock runs only while its gating bit is one
// [RQ2] access to a peripheral with its bit clear gets a bus fault
// [RQ3] all gating bits reset to zero, every peripheral starts unclocked
// [RQ4] software sets a peripheral's bit before touching that peripheral
// [RQ5] run register governs in run mode, sleep registers in low power
// [RQ6] auto gating select picks sleep registers during sleep and deep sleep
// [RQ7] timers 3 to 0 sit at bits 19 down to 16
// [RQ8] two-wire unit 1 at bit 14, unit 0 at bit 12
// [RQ9] synchronous serial unit 1 at bit 5, unit 0 at bit 4
// [RQ10] asynchronous serial units 2, 1, 0 at bits 2, 1, 0
// [RQ11] analog comparator 0 has its own gating bit with same behaviour
// [RQ12] reserved bits are read-only and read as zero
// [RQ13] writes touch only implemented read-write gating bits
//
// The APB slave port was decided locally.
`timescale 1ns/10ps
`include "rpcg_regs.svh"
module rpcg_top #(
  parameter int NUM_GATES = `RPCG_NUM_GATES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // processor power state
  input wire logic [2:0] power_mode,
  // peripheral access check: index of target peripheral and access strobe
  input wire logic periph_access,
  input wire logic [3:0] periph_index,
  output logic periph_fault,
  // gated clocks and enables
  output logic [NUM_GATES-1:0] periph_clk,
  output logic [NUM_GATES-1:0] periph_enable,
  // interrupt
  output logic irq
);
  import rpcg_pkg::*;

  // bit position of each controlled peripheral, index 0 upward
  // the last entry of the list is index 0, so the list runs from the top index down
  localparam logic [NUM_GATES*5-1:0] GATE_POS = {
    `RPCG_BIT_COMPARATOR_0, // index 11 [RQ11]
    `RPCG_BIT_GP_COUNTER_3, // index 10 [RQ7]
    `RPCG_BIT_GP_COUNTER_2, // index 9 [RQ7]
    `RPCG_BIT_GP_COUNTER_1, // index 8 [RQ7]
    `RPCG_BIT_GP_COUNTER_0, // index 7 [RQ7]
    `RPCG_BIT_TWO_WIRE_1, // index 6 [RQ8]
    `RPCG_BIT_TWO_WIRE_0, // index 5 [RQ8]
    `RPCG_BIT_SYNC_SERIAL_1, // index 4 [RQ9]
    `RPCG_BIT_SYNC_SERIAL_0, // index 3 [RQ9]
    `RPCG_BIT_ASYNC_SERIAL_2, // index 2 [RQ10]
    `RPCG_BIT_ASYNC_SERIAL_1, // index 1 [RQ10]
    `RPCG_BIT_ASYNC_SERIAL_0 // index 0 [RQ10]
  };

  rpcg_word_t run_peripheral_clock_gates_1;
  rpcg_word_t sleep_peripheral_clock_gates_1;
  rpcg_word_t deep_sleep_peripheral_clock_gates_1;
  rpcg_word_t run_clock_configuration;
  rpcg_word_t irq_status;
  rpcg_word_t irq_mask;
  rpcg_word_t next_irq_status;
  rpcg_word_t active_gates;
  rpcg_word_t read_mux;

  // apb decode; slave always answers in the access cycle with no wait
  wire wr_access = psel & penable & pwrite;
  wire rd_access = psel & penable & ~pwrite;
  wire hit_run = (paddr == `RPCG_OFF_RUN_GATES);
  wire hit_sleep = (paddr == `RPCG_OFF_SLEEP_GATES);
  wire hit_dsleep = (paddr == `RPCG_OFF_DSLEEP_GATES);
  wire hit_cfg = (paddr == `RPCG_OFF_CLK_CONFIG);
  wire hit_stat = (paddr == `RPCG_OFF_IRQ_STATUS);
  wire hit_mask = (paddr == `RPCG_OFF_IRQ_MASK);
  wire hit_any = hit_run | hit_sleep | hit_dsleep | hit_cfg | hit_stat | hit_mask;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // gating registers; reserved bits drop writes and read zero
  rpcg_gate_reg #(
    .WMASK(`RPCG_GATES_WMASK),
    .RESET(`RPCG_GATES_RESET)
  ) u_run_gates ( // [RQ3] [RQ12] [RQ13]
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_access & hit_run),
    .wdata(pwdata),
    .value(run_peripheral_clock_gates_1)
  );

  rpcg_gate_reg #(
    .WMASK(`RPCG_GATES_WMASK),
    .RESET(`RPCG_GATES_RESET)
  ) u_sleep_gates (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_access & hit_sleep),
    .wdata(pwdata),
    .value(sleep_peripheral_clock_gates_1)
  );

  rpcg_gate_reg #(
    .WMASK(`RPCG_GATES_WMASK),
    .RESET(`RPCG_GATES_RESET)
  ) u_dsleep_gates (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_access & hit_dsleep),
    .wdata(pwdata),
    .value(deep_sleep_peripheral_clock_gates_1)
  );

  // only the auto gating select bit is implemented in the configuration word
  rpcg_gate_reg #(
    .WMASK(32'h1 << `RPCG_CFG_AUTO_GATING_BIT),
    .RESET(`RPCG_CFG_RESET)
  ) u_clk_cfg (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_access & hit_cfg),
    .wdata(pwdata),
    .value(run_clock_configuration)
  );

  rpcg_gate_reg #(
    .WMASK(`RPCG_IRQ_WMASK),
    .RESET(`RPCG_IRQ_RESET)
  ) u_irq_mask (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_access & hit_mask),
    .wdata(pwdata),
    .value(irq_mask)
  );

  wire auto_gating_select = run_clock_configuration[`RPCG_CFG_AUTO_GATING_BIT];

  // choose the governing register by power state
  always_comb begin
    active_gates = run_peripheral_clock_gates_1; // [RQ5]
    if (auto_gating_select) begin
      unique case (power_mode)
        RPCG_SLEEP: active_gates = sleep_peripheral_clock_gates_1; // [RQ6]
        RPCG_DEEP_SLEEP: active_gates = deep_sleep_peripheral_clock_gates_1; // [RQ6]
        default: active_gates = run_peripheral_clock_gates_1;
      endcase
    end
  end

  // one enable and one gated clock per peripheral
  genvar g;
  generate
    for (g = 0; g < NUM_GATES; g = g + 1) begin : gen_gate
      assign periph_enable[g] = active_gates[GATE_POS[g*5 +: 5]]; // [RQ1]
      rpcg_clock_gate u_cg (
        .clk_in(pclk),
        .enable(periph_enable[g]),
        .clk_out(periph_clk[g])
      );
    end
  endgenerate

  // a peripheral access to an unclocked unit faults; the index must be valid
  wire index_ok = (periph_index < 4'(NUM_GATES));
  wire target_on = index_ok & periph_enable[periph_index];
  assign periph_fault = periph_access & ~target_on; // [RQ2]

  // sticky fault flag: a new fault wins over a write-one clear in the same cycle
  always_comb begin
    next_irq_status = irq_status;
    if (wr_access & hit_stat) begin
      next_irq_status = irq_status & ~(pwdata & `RPCG_IRQ_WMASK);
    end
    if (periph_fault) begin
      next_irq_status[`RPCG_IRQ_FAULT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= `RPCG_IRQ_RESET;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // read mux; unmapped addresses read zero with an error
  assign read_mux = hit_run ? run_peripheral_clock_gates_1 :
                    hit_sleep ? sleep_peripheral_clock_gates_1 :
                    hit_dsleep ? deep_sleep_peripheral_clock_gates_1 :
                    hit_cfg ? run_clock_configuration :
                    hit_stat ? irq_status :
                    hit_mask ? irq_mask : 32'h00000000;
  assign prdata = rd_access ? read_mux : 32'h00000000;
endmodule

// file: tb/rpcg_top_properties.sv
// assertion checker for the run-mode peripheral clock gate block
`timescale 1ns/10ps
module rpcg_top_properties #(
  parameter int NUM_GATES = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // power state and peripheral access
  input wire logic [2:0] power_mode,
  input wire logic periph_access,
  input wire logic [3:0] periph_index,
  input wire logic periph_fault,
  // gates and interrupt
  input wire logic [NUM_GATES-1:0] periph_clk,
  input wire logic [NUM_GATES-1:0] periph_enable,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // register bits in peripheral index order, comparator on top
  function automatic logic [11:0] gmap(input logic [31:0] w);
    return {w[24], w[19:16], w[14], w[12], w[5:4], w[2:0]};
  endfunction
  fault_range_a: assert property (periph_access && periph_index > 4'd11 |-> periph_fault)
    else $error("fault missing for index beyond range");
  fault_gate_a: assert property (periph_access && periph_index < 4'd12
    |-> periph_fault == !periph_enable[periph_index])
    else $error("fault does not follow gate bit");
  fault_idle_a: assert property (!periph_access |-> !periph_fault)
    else $error("fault without access");
  rst_zero_a: assert property ($rose(presetn) |-> periph_enable == '0)
    else $error("gate not zero after reset");
  wr_map_a: assert property (psel && penable && pwrite && paddr == 12'h104
    && power_mode == 3'b001 |=> periph_enable == gmap($past(pwdata)))
    else $error("gate bits mapped wrongly");
  rsv_zero_a: assert property (psel && penable && !pwrite && paddr == 12'h104
    |-> (prdata & ~32'h010f5037) == 32'h0)
    else $error("reserved bit reads nonzero");
  run_stable_a: assert property (power_mode == 3'b001 && $stable(power_mode)
    && !$past(psel && penable && pwrite) |-> $stable(periph_enable))
    else $error("gate changed without write");
  irq_cause_a: assert property ($rose(irq) |-> $past(periph_fault)
    || $past(psel && penable && pwrite && paddr == 12'h204))
    else $error("interrupt without cause");
endmodule
bind rpcg_top rpcg_top_properties #(.NUM_GATES(NUM_GATES)) chk_i (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .power_mode,
  .periph_access, .periph_index, .periph_fault, .periph_clk, .periph_enable, .irq);

// file: tb/rpcg_top_bench.sv
// self-checking bench for the run-mode peripheral clock gate block
`timescale 1ns/10ps
module rpcg_top_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, periph_access = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [2:0] power_mode = 3'b001;
  logic [3:0] periph_index = 0;
  logic [11:0] periph_clk, periph_enable;
  logic pready, pslverr, periph_fault, irq, er, f, q;
  int failures = 0, num_checks = 0;
  int pos[12] = '{0, 1, 2, 4, 5, 12, 14, 16, 17, 18, 19, 24};
  rpcg_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .power_mode, .periph_access, .periph_index, .periph_fault,
    .periph_clk, .periph_enable, .irq);
  // free-running 100 MHz clock
  initial begin
    forever #5 pclk = ~pclk;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one apb transfer; one idle edge after release avoids a double drive
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // one-cycle access strobe to a peripheral, then the interrupt two edges on
  task poke(input logic [3:0] ix);
    periph_access <= 1;
    periph_index <= ix;
    #1 f = periph_fault;
    @(posedge pclk);
    periph_access <= 0;
    @(posedge pclk);
    #1 q = irq;
    @(posedge pclk);
  endtask
  task t_map;
    apb(0, 12'h104, 0);
    chk(rd, 0);
    apb(1, 12'h104, 32'hffffffff);
    chk(er, 0);
    apb(0, 12'h104, 0);
    chk(rd, 32'h010f5037);
    for (int i = 0; i < 12; i++) begin
      apb(1, 12'h104, 32'h1 << pos[i]);
      #3;
      chk(32'(periph_clk), 32'h1 << i);
      @(posedge pclk);
    end
    $display("map test done");
  endtask
  task t_fault;
    apb(1, 12'h204, 1);
    poke(0);
    chk(f, 1);
    chk(q, 1);
    poke(11);
    chk(f, 0);
    poke(12);
    chk(f, 1);
    apb(1, 12'h200, 1);
    chk(irq, 0);
    apb(1, 12'h204, 0);
    poke(7);
    chk(q, 0);
    apb(0, 12'h200, 0);
    chk(rd, 1);
    apb(0, 12'h300, 0);
    chk(er, 1);
    $display("fault test done");
  endtask
  task t_mode;
    apb(1, 12'h114, 0);
    apb(1, 12'h124, 32'h1);
    apb(1, 12'h060, 32'h08000000);
    power_mode <= 3'b010;
    repeat (2) @(posedge pclk);
    chk(periph_enable, 0);
    power_mode <= 3'b100;
    repeat (2) @(posedge pclk);
    chk(periph_enable, 12'h001);
    apb(1, 12'h060, 0);
    chk(periph_enable, 12'h800);
    power_mode <= 3'b001;
    repeat (2) @(posedge pclk);
    chk(periph_enable, 12'h800);
    $display("mode test done");
  endtask
  task tally_and_finish;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // main sequence after ten reset cycles
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk(periph_enable, 0);
    t_map;
    t_fault;
    t_mode;
    tally_and_finish;
  end
  // watchdog well beyond the roughly 115 cycles the tests need
  initial begin
    #20000;
    failures++;
    tally_and_finish;
  end
endmodule
